// File: verilog/ppfs_params.svh
// Offsets, field positions and reset values of the port pin function block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH

`define PPFS_OFS_IOCR_P72 8'h00
`define PPFS_OFS_IOCR_P83 8'h04
`define PPFS_OFS_IOCR_P84 8'h08
`define PPFS_OFS_GPOUT    8'h0c
`define PPFS_OFS_PADIN    8'h10
`define PPFS_OFS_STATUS   8'h14

`define PPFS_SEL_LSB      0
`define PPFS_SEL_MSB      3
`define PPFS_SEL_OE_BIT   3
`define PPFS_SEL_SRC_MSB  1

`define PPFS_IOCR_RST     4'h0
`define PPFS_GPOUT_RST    3'h0

`define PPFS_ST_DBG_ACT   0
`define PPFS_ST_DBG_RDY   1
`define PPFS_ST_TEST      2
`define PPFS_ST_JTAG_C    3
`define PPFS_ST_JTAG_D    4

`define PPFS_RESP_OKAY    2'b00
`define PPFS_RESP_SLVERR  2'b10

`endif

// File: verilog/ppfs_pkg.sv
// Types shared by the port pin function block.
// Assumes the constants header is compiled alongside.
package ppfs_pkg;

   typedef logic [3:0] ppfs_sel_t;

   // Hardware owner of a pin: takes the pad away from the selection field
   typedef struct packed {
      logic own;
      logic val;
   } ppfs_hw_t;

   typedef enum {PPFS_IDLE, PPFS_RESP} ppfs_bus_st_t;

endpackage

// File: verilog/ppfs_pin_mux.sv
// One port pin output selector: software field plus hardware override.
// Assumes the four candidate sources are already synchronous to aclk.
`timescale 1ns/10ps
`include "ppfs_params.svh"

module ppfs_pin_mux
   import ppfs_pkg::*;
(
   input  wire ppfs_sel_t  sel,
   input  wire logic [3:0] src,
   input  wire ppfs_hw_t   hw,
   output wire logic       out,
   output wire logic       oe
);

   wire logic [1:0] src_idx;
   wire logic       sw_oe;

   // Bit 2 plays no part in picking the source
   assign src_idx = sel[`PPFS_SEL_SRC_MSB:`PPFS_SEL_LSB]; // R15
   assign sw_oe   = sel[`PPFS_SEL_OE_BIT]; // R1
   // Hardware owner wins over the field
   assign out = hw.own ? hw.val : src[src_idx]; // R2 R1
   assign oe  = hw.own | sw_oe; // R2

endmodule // ppfs_pin_mux

// File: verilog/ppfs_dbg_strap.sv
// Debug enable and JTAG position straps caught at the power-on reset release.
// Assumes power_on_reset_in is active low and synchronous to aclk.
`timescale 1ns/10ps

module ppfs_dbg_strap
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic power_on_reset_in,
   input  wire logic debug_reset_in,
   input  wire logic jtag_pos_c_strap,
   input  wire logic jtag_pos_d_strap,
   output logic      debug_active,
   output logic      debug_ready,
   output logic      jtag_pos_c_sel,
   output logic      jtag_pos_d_sel
);

   logic por_q;
   wire logic por_rise;

   // Reset high so a released reset line is not mistaken for an edge
   assign por_rise = power_on_reset_in & ~por_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         por_q          <= 1'b1;
         debug_active   <= 1'b0;
         debug_ready    <= 1'b0;
         jtag_pos_c_sel <= 1'b0;
         jtag_pos_d_sel <= 1'b0;
      end
      else
      begin
         por_q <= power_on_reset_in;
         if (!power_on_reset_in)
         begin
            debug_active <= 1'b0;
            debug_ready  <= 1'b0;
         end
         else if (por_rise)
         begin
            debug_active   <= debug_reset_in; // R5
            debug_ready    <= 1'b0;
            jtag_pos_c_sel <= jtag_pos_c_strap;
            jtag_pos_d_sel <= jtag_pos_d_strap;
         end
         // Debug logic marked ready once its reset is seen low after activation
         else if (debug_active && !debug_reset_in)
            debug_ready <= 1'b1; // R6
      end
   end

endmodule // ppfs_dbg_strap

// File: verilog/ppfs_port_pins.sv
// Port pin function selection for three port pins, test and debug pins.
// Assumes AXI4-Lite master on aclk; pads resolved outside from out/oe/pull.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "ppfs_params.svh"

// Contract
// R1: Each pin's output source follows its selection field, 1x00 picking source zero.
// R2: A hardware owner drives its pin directly, bypassing the selection field.
// R3: Factory test mode is on unless the test enable pin is high; it has a pull-up.
// R4: The board keeps the debug reset input low in normal operation.
// R5: Debug is activated if debug reset is high at the power-on reset rising edge.
// R6: After activation the board pulses debug reset low once before debug use.
// R7: The debug reset input has an internal pull-down.
// R8: JTAG position C at start-up enables a pull-up on port 7 bit 2.
// R9: JTAG position D at start-up enables pulls on port 8 bits 4 and 3.
// R10: Port 7 bit 2 offers GPIO, analog mux control 0, CAN 4 and CAN 5 transmit.
// R11: Port 7 bit 2 pad feeds capture unit 62 position input 0 and position-C data in.
// R12: Port 8 bit 4 offers unit 60 ch1 compl and unit 62 ch1 out, and feeds TMS-D and ch1 in.
// R13: Port 8 bit 3 offers unit 60 ch0 compl and unit 62 ch0 out, and feeds TDI-D and ch0 in.
// R14: Every pin is always readable and drives its port output bit on selection zero.
// R15: The field is four bits; bit 2 is ignored and bits 1:0 pick the source.
module ppfs_port_pins
   import ppfs_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Pads: 0 port7_bit2, 1 port8_bit3, 2 port8_bit4
   input  wire logic [2:0]        pad_in,
   output logic [2:0]             pad_out,
   output logic [2:0]             pad_oe,
   output logic [2:0]             pad_pu_en,
   // Test and debug pins
   input  wire logic              factory_test_enable_in,
   output logic                   factory_test_pu_en,
   output logic                   factory_test_mode,
   input  wire logic              power_on_reset_in,
   input  wire logic              debug_reset_in,
   output logic                   debug_reset_pd_en,
   output logic                   debug_active,
   output logic                   debug_ready,
   input  wire logic              jtag_pos_c_strap,
   input  wire logic              jtag_pos_d_strap,
   // Peripheral output sources
   input  wire logic              ext_analog_mux_ctrl0,
   input  wire logic              can_node4_tx,
   input  wire logic              can_node5_tx,
   input  wire logic              capture_unit60_ch1_compl_out,
   input  wire logic              capture_unit62_ch1_out,
   input  wire logic              capture_unit60_ch0_compl_out,
   input  wire logic              capture_unit62_ch0_out,
   input  wire ppfs_hw_t          hw_port7_bit2,
   input  wire ppfs_hw_t          hw_port8_bit3,
   input  wire ppfs_hw_t          hw_port8_bit4,
   // Pad levels to peripherals
   output logic                   capture_unit62_position_in0,
   output logic                   tdi_c_in,
   output logic                   tms_d_in,
   output logic                   tdi_d_in,
   output logic                   capture_unit62_ch1_in,
   output logic                   capture_unit62_ch0_in
);

   ppfs_sel_t      iocr_p72_q;
   ppfs_sel_t      iocr_p83_q;
   ppfs_sel_t      iocr_p84_q;
   logic [2:0]     gpout_q;
   logic [2:0]     pad_in_q;
   logic           aw_have_q;
   logic           w_have_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]    wdata_q;
   logic [3:0]     wstrb_q;
   ppfs_bus_st_t   wr_st_q;
   logic           jtag_c_sel;
   logic           jtag_d_sel;

   wire logic      aw_fire;
   wire logic      w_fire;
   wire logic      ar_fire;
   wire logic      wr_go;
   wire logic      wr_lane0;
   wire logic      wr_iocr_p72;
   wire logic      wr_iocr_p83;
   wire logic      wr_iocr_p84;
   wire logic      wr_gpout;
   wire logic      wr_mapped;
   wire logic      rd_mapped;
   wire logic [31:0] rd_word;
   wire logic [4:0]  status_word;
   wire logic [3:0]  src_p72;
   wire logic [3:0]  src_p83;
   wire logic [3:0]  src_p84;
   wire logic [2:0]  mux_out;
   wire logic [2:0]  mux_oe;

   // Bus handshakes
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire  = s_axi_wvalid & s_axi_wready;
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign wr_go   = aw_have_q & w_have_q & (wr_st_q == PPFS_IDLE);

   // Write decode; all fields live in byte lane 0
   assign wr_lane0    = wr_go & wstrb_q[0];
   assign wr_iocr_p72 = wr_lane0 & (awaddr_q == `PPFS_OFS_IOCR_P72);
   assign wr_iocr_p83 = wr_lane0 & (awaddr_q == `PPFS_OFS_IOCR_P83);
   assign wr_iocr_p84 = wr_lane0 & (awaddr_q == `PPFS_OFS_IOCR_P84);
   assign wr_gpout    = wr_lane0 & (awaddr_q == `PPFS_OFS_GPOUT);
   assign wr_mapped   = (awaddr_q == `PPFS_OFS_IOCR_P72) | (awaddr_q == `PPFS_OFS_IOCR_P83)
                      | (awaddr_q == `PPFS_OFS_IOCR_P84) | (awaddr_q == `PPFS_OFS_GPOUT)
                      | (awaddr_q == `PPFS_OFS_PADIN) | (awaddr_q == `PPFS_OFS_STATUS);

   // Read decode
   assign status_word[`PPFS_ST_DBG_ACT] = debug_active;
   assign status_word[`PPFS_ST_DBG_RDY] = debug_ready;
   assign status_word[`PPFS_ST_TEST]    = factory_test_mode;
   assign status_word[`PPFS_ST_JTAG_C]  = jtag_c_sel;
   assign status_word[`PPFS_ST_JTAG_D]  = jtag_d_sel;

   assign rd_mapped = (s_axi_araddr == `PPFS_OFS_IOCR_P72)
                    | (s_axi_araddr == `PPFS_OFS_IOCR_P83)
                    | (s_axi_araddr == `PPFS_OFS_IOCR_P84)
                    | (s_axi_araddr == `PPFS_OFS_GPOUT)
                    | (s_axi_araddr == `PPFS_OFS_PADIN)
                    | (s_axi_araddr == `PPFS_OFS_STATUS);
   assign rd_word =
      (s_axi_araddr == `PPFS_OFS_IOCR_P72) ? {28'h0000000, iocr_p72_q} :
      (s_axi_araddr == `PPFS_OFS_IOCR_P83) ? {28'h0000000, iocr_p83_q} :
      (s_axi_araddr == `PPFS_OFS_IOCR_P84) ? {28'h0000000, iocr_p84_q} :
      (s_axi_araddr == `PPFS_OFS_GPOUT)    ? {29'h00000000, gpout_q} :
      (s_axi_araddr == `PPFS_OFS_PADIN)    ? {29'h00000000, pad_in_q} : // R14
      (s_axi_araddr == `PPFS_OFS_STATUS)   ? {27'h0000000, status_word} :
                                             32'h00000000;

   // Source tables, index is the low two field bits
   assign src_p72 = {can_node5_tx, can_node4_tx, ext_analog_mux_ctrl0, gpout_q[0]}; // R10 R14
   assign src_p83 = {1'b0, capture_unit62_ch0_out, capture_unit60_ch0_compl_out,
                     gpout_q[1]}; // R13 R14
   assign src_p84 = {1'b0, capture_unit62_ch1_out, capture_unit60_ch1_compl_out,
                     gpout_q[2]}; // R12 R14

   ppfs_pin_mux u_mux_p72
   (
      .sel (iocr_p72_q),
      .src (src_p72),
      .hw  (hw_port7_bit2),
      .out (mux_out[0]),
      .oe  (mux_oe[0])
   );

   ppfs_pin_mux u_mux_p83
   (
      .sel (iocr_p83_q),
      .src (src_p83),
      .hw  (hw_port8_bit3),
      .out (mux_out[1]),
      .oe  (mux_oe[1])
   );

   ppfs_pin_mux u_mux_p84
   (
      .sel (iocr_p84_q),
      .src (src_p84),
      .hw  (hw_port8_bit4),
      .out (mux_out[2]),
      .oe  (mux_oe[2])
   );

   ppfs_dbg_strap u_dbg
   (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .power_on_reset_in (power_on_reset_in),
      .debug_reset_in    (debug_reset_in),
      .jtag_pos_c_strap  (jtag_pos_c_strap),
      .jtag_pos_d_strap  (jtag_pos_d_strap),
      .debug_active      (debug_active),
      .debug_ready       (debug_ready),
      .jtag_pos_c_sel    (jtag_c_sel),
      .jtag_pos_d_sel    (jtag_d_sel)
   );

   // Write address and data are taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PPFS_RESP_OKAY;
         wr_st_q       <= PPFS_IDLE;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_fire)
         begin
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         case (wr_st_q)
            PPFS_IDLE:
               if (wr_go)
               begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wr_mapped ? `PPFS_RESP_OKAY : `PPFS_RESP_SLVERR;
                  wr_st_q      <= PPFS_RESP;
               end
            PPFS_RESP:
               if (s_axi_bready)
               begin
                  s_axi_bvalid  <= 1'b0;
                  aw_have_q     <= 1'b0;
                  w_have_q      <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready  <= 1'b1;
                  wr_st_q       <= PPFS_IDLE;
               end
            default:
               wr_st_q <= PPFS_IDLE;
         endcase
      end
   end

   // Read channel: one read under way at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PPFS_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_mapped ? `PPFS_RESP_OKAY : `PPFS_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Control registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         iocr_p72_q <= `PPFS_IOCR_RST;
         iocr_p83_q <= `PPFS_IOCR_RST;
         iocr_p84_q <= `PPFS_IOCR_RST;
         gpout_q    <= `PPFS_GPOUT_RST;
      end
      else
      begin
         if (wr_iocr_p72)
            iocr_p72_q <= wdata_q[`PPFS_SEL_MSB:`PPFS_SEL_LSB]; // R1
         if (wr_iocr_p83)
            iocr_p83_q <= wdata_q[`PPFS_SEL_MSB:`PPFS_SEL_LSB]; // R1
         if (wr_iocr_p84)
            iocr_p84_q <= wdata_q[`PPFS_SEL_MSB:`PPFS_SEL_LSB]; // R1
         if (wr_gpout)
            gpout_q <= wdata_q[2:0]; // R14
      end
   end

   // Pads and pad levels, one register stage each way
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pad_out            <= 3'h0;
         pad_oe             <= 3'h0;
         pad_pu_en          <= 3'h0;
         pad_in_q           <= 3'h0;
         factory_test_pu_en <= 1'b1;
         factory_test_mode  <= 1'b0;
         debug_reset_pd_en  <= 1'b1;
      end
      else
      begin
         pad_out            <= mux_out; // R1 R2
         pad_oe             <= mux_oe; // R1 R2
         pad_pu_en          <= {jtag_d_sel, jtag_d_sel, jtag_c_sel}; // R8 R9
         pad_in_q           <= pad_in; // R14
         factory_test_pu_en <= 1'b1; // R3
         // Any level but high counts as test request
         factory_test_mode  <= (factory_test_enable_in !== 1'b1); // R3
         debug_reset_pd_en  <= 1'b1; // R7
      end
   end

   // Pad levels handed to peripherals
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         capture_unit62_position_in0 <= 1'b0;
         tdi_c_in                    <= 1'b0;
         tms_d_in                    <= 1'b0;
         tdi_d_in                    <= 1'b0;
         capture_unit62_ch1_in       <= 1'b0;
         capture_unit62_ch0_in       <= 1'b0;
      end
      else
      begin
         capture_unit62_position_in0 <= pad_in[0]; // R11
         tdi_c_in                    <= pad_in[0]; // R11
         tdi_d_in                    <= pad_in[1]; // R13
         capture_unit62_ch0_in       <= pad_in[1]; // R13
         tms_d_in                    <= pad_in[2]; // R12
         capture_unit62_ch1_in       <= pad_in[2]; // R12
      end
   end

endmodule // ppfs_port_pins

// File: sim/ppfs_assertions.sv
// Checker for the port pin function block.
// Bound to ppfs_port_pins; sees only its ports.
`timescale 1ns/10ps

module ppfs_chk
   import ppfs_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [2:0] pad_in,
   input wire logic [2:0] pad_out,
   input wire logic [2:0] pad_oe,
   input wire logic [2:0] pad_pu_en,
   input wire ppfs_hw_t   hw_port7_bit2,
   input wire logic       factory_test_enable_in,
   input wire logic       factory_test_pu_en,
   input wire logic       factory_test_mode,
   input wire logic       power_on_reset_in,
   input wire logic       debug_reset_in,
   input wire logic       debug_reset_pd_en,
   input wire logic       debug_active,
   input wire logic       debug_ready,
   input wire logic       jtag_pos_c_strap,
   input wire logic       jtag_pos_d_strap,
   input wire logic       tdi_c_in,
   input wire logic       capture_unit62_position_in0,
   input wire logic       tms_d_in,
   input wire logic       capture_unit62_ch1_in,
   input wire logic       tdi_d_in,
   input wire logic       capture_unit62_ch0_in
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Registered outputs: the cycle before must be out of reset
   a_test_mode: assert property ($past(aresetn) |->
      factory_test_mode == !$past(factory_test_enable_in)) else $error("test mode wrong");
   a_pin_pulls: assert property (factory_test_pu_en && debug_reset_pd_en)
      else $error("fixed pull off");
   a_hw_own: assert property ($past(aresetn) && $past(hw_port7_bit2.own) |->
      pad_oe[0] && pad_out[0] == $past(hw_port7_bit2.val)) else $error("override lost");
   a_feed_c: assert property ($past(aresetn) |->
      tdi_c_in == $past(pad_in[0]) && capture_unit62_position_in0 == $past(pad_in[0]))
      else $error("port7 feed wrong");
   a_feed_d: assert property ($past(aresetn) |->
      {tms_d_in, capture_unit62_ch1_in, tdi_d_in, capture_unit62_ch0_in}
      == {{2{$past(pad_in[2])}}, {2{$past(pad_in[1])}}}) else $error("port8 feed wrong");
   a_debug_act: assert property ($rose(power_on_reset_in) |=>
      debug_active == $past(debug_reset_in)) else $error("debug strap wrong");
   a_debug_rdy: assert property ($rose(debug_ready) |->
      $past(debug_active) && !$past(debug_reset_in)) else $error("debug ready early");
   a_pull_c: assert property ($rose(power_on_reset_in) && jtag_pos_c_strap |->
      ##[1:2] pad_pu_en[0]) else $error("position C pull off");
   a_pull_d: assert property ($rose(power_on_reset_in) && jtag_pos_d_strap |->
      ##[1:2] pad_pu_en[2:1] == 2'h3) else $error("position D pulls off");

   c_debug: cover property ($rose(debug_active));
   c_own: cover property (hw_port7_bit2.own);
   c_test: cover property (factory_test_mode);
endmodule // ppfs_chk

bind ppfs_port_pins ppfs_chk u_chk (.aclk, .aresetn, .pad_in, .pad_out, .pad_oe, .pad_pu_en,
   .hw_port7_bit2, .factory_test_enable_in, .factory_test_pu_en, .factory_test_mode,
   .power_on_reset_in, .debug_reset_in, .debug_reset_pd_en, .debug_active, .debug_ready,
   .jtag_pos_c_strap, .jtag_pos_d_strap, .tdi_c_in, .capture_unit62_position_in0,
   .tms_d_in, .capture_unit62_ch1_in, .tdi_d_in, .capture_unit62_ch0_in);

// File: sim/ppfs_board.sv
// Board model: resolves the three pads and the test and debug pins.
// Assumes the bench sets the external levels just after clock edges.
`timescale 1ns/10ps

module ppfs_board
(
   input  wire logic       aclk,
   input  wire logic [2:0] pad_out,
   input  wire logic [2:0] pad_oe,
   input  wire logic [2:0] pad_pu_en,
   input  wire logic [2:0] ext_en,
   input  wire logic [2:0] ext_val,
   input  wire logic       test_en,
   input  wire logic       test_val,
   input  wire logic       dbg_en,
   input  wire logic       dbg_val,
   output logic [2:0]      pad_in,
   output logic            test_pin,
   output logic            dbg_pin
);
   logic tog_q = 1'b0;

   // Floating pad without pull shows a pattern, never a held value
   always @(posedge aclk)
      tog_q <= !tog_q;
   always_comb
      for (int i = 0; i < 3; i++)
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pu_en[i] | tog_q;
   assign test_pin = test_en ? test_val : 1'b1;
   assign dbg_pin = dbg_en ? dbg_val : 1'b0;
endmodule // ppfs_board

// File: sim/port_pin_function_select_test.sv
// Self-checking bench for the port pin function block.
// Assumes the board model resolves pads, test and debug pins.
`timescale 1ns/10ps
`include "ppfs_params.svh"

module port_pin_function_select_test
   import ppfs_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, src [3] = '{4'h0, 4'h0, 4'h0};
   logic awready, wready, bvalid, arready, rvalid, test_pin, dbg_pin;
   logic [1:0] bresp, rresp;
   logic [2:0] pad_in, pad_out, pad_oe, pad_pu_en, ext_en = 3'h0, ext_val = 3'h0;
   logic test_en = 1'b0, test_val = 1'b0, dbg_en = 1'b0, dbg_val = 1'b0;
   logic por = 1'b1, strap_c = 1'b0, strap_d = 1'b0;
   ppfs_hw_t hw [3] = '{2'h0, 2'h0, 2'h0};
   logic [7:0] ofs [3] = '{`PPFS_OFS_IOCR_P72, `PPFS_OFS_IOCR_P83, `PPFS_OFS_IOCR_P84};
   localparam logic [1:0] ok_r = `PPFS_RESP_OKAY;
   int n_fail = 0, n_checks = 0, cycles = 0;

   ppfs_port_pins uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu_en(pad_pu_en),
      .factory_test_enable_in(test_pin), .factory_test_pu_en(), .factory_test_mode(),
      .power_on_reset_in(por), .debug_reset_in(dbg_pin), .debug_reset_pd_en(),
      .debug_active(), .debug_ready(), .jtag_pos_c_strap(strap_c),
      .jtag_pos_d_strap(strap_d), .ext_analog_mux_ctrl0(src[0][1]),
      .can_node4_tx(src[0][2]), .can_node5_tx(src[0][3]),
      .capture_unit60_ch1_compl_out(src[2][1]), .capture_unit62_ch1_out(src[2][2]),
      .capture_unit60_ch0_compl_out(src[1][1]), .capture_unit62_ch0_out(src[1][2]),
      .hw_port7_bit2(hw[0]), .hw_port8_bit3(hw[1]), .hw_port8_bit4(hw[2]),
      .capture_unit62_position_in0(), .tdi_c_in(), .tms_d_in(), .tdi_d_in(),
      .capture_unit62_ch1_in(), .capture_unit62_ch0_in());

   ppfs_board board (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu_en(pad_pu_en),
      .ext_en(ext_en), .ext_val(ext_val), .test_en(test_en), .test_val(test_val),
      .dbg_en(dbg_en), .dbg_val(dbg_val), .pad_in(pad_in), .test_pin(test_pin),
      .dbg_pin(dbg_pin));

   always
      #25 aclk = !aclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      chk(bresp, er, "write response");
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid);
      d = rdata;
      chk(rresp, er, "read response");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Whole run needs about 550 cycles
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         results();
      end
   end

   initial
   begin
      logic [31:0] d;
      logic [3:0] sv;
      logic e;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int p = 0; p < 6; p++)
      begin
         rd(8'(p * 4), d, ok_r);
         if (p != 4) chk(d, 32'h0, "reset value");
      end
      chk(pad_oe, 3'h0, "pins start as inputs");
      wr(`PPFS_OFS_IOCR_P72, 32'h8, 4'h0, ok_r);
      rd(`PPFS_OFS_IOCR_P72, d, ok_r);
      chk(d, 32'h0, "strobe-less write");
      wr(8'h18, 32'h1, 4'hf, `PPFS_RESP_SLVERR);
      rd(8'h18, d, `PPFS_RESP_SLVERR);
      $display("registers done");
      for (int p = 0; p < 3; p++)
      begin
         for (int s = 0; s < 8; s++)
         begin
            wr(ofs[p], 32'(8 + s), 4'hf, ok_r);
            rd(ofs[p], d, ok_r);
            chk(d, 32'(8 + s), "selection readback");
            for (int v = 0; v < 2; v++)
            begin
               // Chosen source differs from all others
               for (int k = 0; k < 4; k++)
                  sv[k] = (k == s % 4) ? v[0] : !v[0];
               e = (p > 0 && s % 4 == 3) ? 1'b0 : sv[s % 4];
               src[p] <= sv;
               wr(`PPFS_OFS_GPOUT, {29'h0, 3'(sv[0]) << p}, 4'hf, ok_r);
               cyc(2);
               chk(pad_oe[p], 1'b1, "output enable");
               chk(pad_out[p], e, "pad source");
               rd(`PPFS_OFS_PADIN, d, ok_r);
               chk(d[p], e, "pad readback");
            end
         end
         wr(ofs[p], 32'h4, 4'hf, ok_r);
         cyc(2);
         chk(pad_oe[p], 1'b0, "output off");
      end
      $display("selection done");
      for (int p = 0; p < 3; p++)
      begin
         hw[p] <= '{own: 1'b1, val: 1'b1};
         cyc(2);
         chk({pad_oe[p], pad_out[p]}, 2'h3, "hardware override");
         hw[p] <= '{own: 1'b0, val: 1'b0};
         cyc(1);
      end
      for (int v = 0; v < 2; v++)
      begin
         ext_en <= 3'h7;
         ext_val <= v ? 3'h5 : 3'h2;
         cyc(2);
         rd(`PPFS_OFS_PADIN, d, ok_r);
         chk(d, v ? 32'h5 : 32'h2, "pad levels");
      end
      ext_en <= 3'h0;
      test_en <= 1'b1;
      cyc(2);
      rd(`PPFS_OFS_STATUS, d, ok_r);
      chk(d[2], 1'b1, "test mode on");
      test_en <= 1'b0;
      cyc(2);
      rd(`PPFS_OFS_STATUS, d, ok_r);
      chk(d[2], 1'b0, "test mode off");
      $display("pins done");
      por <= 1'b0;
      dbg_en <= 1'b1;
      dbg_val <= 1'b1;
      strap_c <= 1'b1;
      strap_d <= 1'b1;
      cyc(2);
      por <= 1'b1;
      cyc(3);
      rd(`PPFS_OFS_STATUS, d, ok_r);
      chk(d[4:0], 5'h19, "debug strap");
      chk(pad_pu_en, 3'h7, "strap pulls");
      for (int i = 0; i < 2; i++)
      begin
         rd(`PPFS_OFS_PADIN, d, ok_r);
         chk(d[2:0], 3'h7, "pulled pads");
      end
      dbg_val <= 1'b0;
      cyc(2);
      rd(`PPFS_OFS_STATUS, d, ok_r);
      chk(d[1:0], 2'h3, "debug ready");
      dbg_en <= 1'b0;
      por <= 1'b0;
      strap_c <= 1'b0;
      strap_d <= 1'b0;
      cyc(2);
      por <= 1'b1;
      cyc(3);
      rd(`PPFS_OFS_STATUS, d, ok_r);
      chk(d[4:0], 5'h0, "debug off");
      chk(pad_pu_en, 3'h0, "no pulls");
      $display("debug done");
      results();
   end
endmodule // port_pin_function_select_test
